// [rtl/step_aux_params.svh]
// Timing figures, reset values and scaling constants of the step speed and aux output logic
`ifndef STEP_AUX_PARAMS_SVH
`define STEP_AUX_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define FILT_UNIT_NS 500000
`define TICKS_PER_S (1000000000 / `FILT_UNIT_NS)
`define ILK_TIME_MS 50
`define STEP_PULSE_MS 100
`define WARN_TIME_UNIT_MS 100
`define HEAVY_WARN_S 36
`define HEAVY_TRIP_S 60
`define HEAVY_LEVEL_PCT 10'h096
`define STEP_FREQ_RST 16'h0bb8
`define METER_DIV_LIN 100
`define METER_DIV_CUR 150
`define METER_FULL 8'hff
`define PCT_FULL 16'h0064
`endif

// [rtl/step_aux_pkg.sv]
// Types shared by the step speed and aux output logic
package step_aux_pkg;
  typedef logic [15:0] freq_t;
  typedef logic [9:0] pct_t;

  typedef struct packed {
    logic spd_x;
    logic spd_h;
    logic spd_m;
    logic spd_l;
  } speed_in_t;

  typedef struct packed {
    logic jog;
    speed_in_t spd;
    logic [2:0] ramp;
  } term_in_t;

  typedef struct packed {
    logic stall;
    logic dc_bus_high;
    logic dc_bus_low;
    logic heatsink_hot;
    logic ref_lost;
    logic running;
    logic speed_search;
  } drive_flags_t;

  typedef struct packed {
    logic ready;
    logic trv_acc;
    logic trv_dec;
    logic mmc;
    logic zero_speed;
    logic torque_det;
  } aux_misc_t;

  typedef struct packed {
    freq_t freq_max;
    logic [15:0] volt;
    logic [15:0] volt_max;
    logic [15:0] dcbus;
    logic [15:0] dcbus_max;
    pct_t torque_pct;
  } meter_src_t;

  typedef enum logic [4:0] {
    AUX_ARRIVE = 5'h00, AUX_BAND_BOTH, AUX_BAND_OUT, AUX_HYST, AUX_HYST_INV, AUX_WARN, AUX_HEAVY,
    AUX_STALL, AUX_DC_HIGH, AUX_DC_LOW, AUX_HOT, AUX_LOST, AUX_RUN, AUX_STOP, AUX_STEADY,
    AUX_INV_LINE, AUX_COMM_LINE, AUX_SEARCH, AUX_STEP_PULSE, AUX_SEQ_PULSE, AUX_READY,
    AUX_TRV_ACC, AUX_TRV_DEC, AUX_MMC, AUX_ZSPD, AUX_TORQ
  } aux_code_t;

  typedef enum logic [2:0] {
    METER_FREQ = 3'h0, METER_CUR, METER_VOLT, METER_DCBUS, METER_TORQUE
  } meter_sel_t;

  typedef enum {LINE_DRIVE, LINE_GAP_COMM, LINE_COMM, LINE_GAP_DRIVE} line_state_t;
endpackage

// [rtl/term_filter.sv]
// Noise filter for the jog, speed and ramp select terminals
`timescale 1ns/10ps
`include "step_aux_params.svh"
module term_filter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic [7:0] filt_setting,
  input wire step_aux_pkg::term_in_t raw,
  output step_aux_pkg::term_in_t clean_q
);
  logic [7:0] cnt_q [8];

  // A change must hold for filt_setting half-ms ticks before it is accepted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clean_q <= '0;
      for (int i = 0; i < 8; i++) begin
        cnt_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (raw[i] == clean_q[i]) begin
          cnt_q[i] <= 8'h00;
        end else if (filt_setting == 8'h00 || (tick && cnt_q[i] + 8'h01 >= filt_setting)) begin
          clean_q[i] <= raw[i];
          cnt_q[i] <= 8'h00;
        end else if (tick) begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end

  filt_bypass_a: assert property (@(posedge clk) disable iff (!rstn)
    (filt_setting == 8'h00 && raw != clean_q) |=> clean_q == $past(raw))
    else $error("unfiltered input not taken in one clock");
endmodule

// [rtl/meter_pwm.sv]
// Pulse-width meter output scaled from the selected quantity and gain
`timescale 1ns/10ps
`include "step_aux_params.svh"
module meter_pwm (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] value,
  input wire logic [15:0] full_scale,
  input wire logic [7:0] gain,
  input wire logic cur_scale,
  output logic meter_pulse_out
);
  logic [31:0] num;
  logic [23:0] den;
  logic [31:0] ratio;
  logic [7:0] duty_q;
  logic [7:0] pwm_q;

  // Average = value / full_scale * 10V * gain / divisor, 255 counts being 10V
  always_comb begin
    num = 32'(value) * 32'(gain) * 32'(`METER_FULL);
    den = 24'(full_scale) * (cur_scale ? 24'(`METER_DIV_CUR) : 24'(`METER_DIV_LIN));
    ratio = (den == 24'h000000) ? 32'h00000000 : num / 32'(den);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      duty_q <= 8'h00;
    end else begin
      duty_q <= (ratio > 32'(`METER_FULL)) ? `METER_FULL : ratio[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_q <= 8'h00;
      meter_pulse_out <= 1'b0;
    end else begin
      pwm_q <= pwm_q + 8'h01;
      meter_pulse_out <= pwm_q < duty_q;
    end
  end

  meter_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (duty_q == 8'h00) [*2] |-> !meter_pulse_out)
    else $error("meter pulse high at zero duty");
endmodule

// [rtl/step_aux_logic.sv]
// Step speed decode, ramp selection, aux relay selection and line exchange of the drive
`timescale 1ns/10ps
`include "step_aux_params.svh"
module step_aux_logic #(
  parameter int HALF_MS_CYCLES = `FILT_UNIT_NS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire step_aux_pkg::term_in_t term_raw,
  input wire logic [7:0] filt_setting,
  input wire logic speed_sel_en,
  input wire logic ramp_sel_en,
  input wire step_aux_pkg::freq_t base_freq,
  input wire step_aux_pkg::freq_t jog_freq,
  input wire logic step_wr_en,
  input wire logic [3:0] step_wr_idx,
  input wire step_aux_pkg::freq_t step_wr_data,
  input wire step_aux_pkg::freq_t out_freq,
  input wire step_aux_pkg::freq_t ref_freq,
  input wire step_aux_pkg::freq_t freq_detect,
  input wire step_aux_pkg::freq_t detect_band,
  input wire step_aux_pkg::pct_t out_current,
  input wire step_aux_pkg::pct_t warn_level,
  input wire logic [7:0] warn_time,
  input wire step_aux_pkg::drive_flags_t flags,
  input wire step_aux_pkg::aux_misc_t misc,
  input wire logic auto_seq_en,
  input wire logic step_event,
  input wire logic seq_event,
  input wire logic line_to_comm,
  input wire logic fault_reset,
  input wire logic [4:0] aux_sel,
  input wire logic [2:0] meter_sel,
  input wire logic [7:0] meter_gain,
  input wire step_aux_pkg::meter_src_t meter_src,
  output step_aux_pkg::freq_t freq_cmd_q,
  output logic [3:0] step_idx_q,
  output logic jog_active_q,
  output logic [2:0] ramp_idx_q,
  output logic aux_relay_contact,
  output logic overload_warning,
  output logic drive_overload,
  output logic inv_line,
  output logic comm_line,
  output logic meter_pulse_out
);
  localparam int TICKS_PER_S = `TICKS_PER_S;
  localparam int ILK_TICKS = `ILK_TIME_MS * TICKS_PER_S / 1000;
  localparam int PULSE_TICKS = `STEP_PULSE_MS * TICKS_PER_S / 1000;
  localparam int WARN_UNIT_TICKS = `WARN_TIME_UNIT_MS * TICKS_PER_S / 1000;
  localparam int HEAVY_WARN_TICKS = `HEAVY_WARN_S * TICKS_PER_S;
  localparam int HEAVY_TRIP_TICKS = `HEAVY_TRIP_S * TICKS_PER_S;

  function automatic logic [16:0] band_low(input logic [15:0] det, input logic [15:0] band);
    logic [16:0] half;
    half = 17'(band >> 1);
    band_low = (17'(det) > half) ? 17'(det) - half : 17'h00000;
  endfunction

  function automatic logic in_band(input logic [15:0] f, input logic [15:0] det,
                                   input logic [15:0] band);
    in_band = 17'(f) >= band_low(det, band) && 17'(f) <= 17'(det) + 17'(band >> 1);
  endfunction

  logic [15:0] div_q;
  logic tick_q;
  step_aux_pkg::term_in_t term_q;
  logic [3:0] spd_idx;
  step_aux_pkg::freq_t step_tbl_q [1:15];
  logic det_hyst_q;
  logic [15:0] warn_cnt_q;
  logic [16:0] heavy_cnt_q;
  logic [7:0] pulse_q;
  step_aux_pkg::line_state_t line_q;
  logic [7:0] gap_q;
  logic cond;
  logic [15:0] meter_val;
  logic [15:0] meter_fs;

  // Half-ms enable drives every slow timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == 16'(HALF_MS_CYCLES - 1);
      div_q <= (div_q == 16'(HALF_MS_CYCLES - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  term_filter u_filter (
    .clk(clk),
    .rstn(rstn),
    .tick(tick_q),
    .filt_setting(filt_setting),
    .raw(term_raw),
    .clean_q(term_q)
  );

  assign spd_idx = speed_sel_en ? term_q.spd : 4'h0;

  // Writes to index zero are dropped: that step is the base frequency input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 1; i < 16; i++) begin
        step_tbl_q[i] <= `STEP_FREQ_RST;
      end
    end else if (step_wr_en && step_wr_idx != 4'h0) begin
      step_tbl_q[step_wr_idx] <= step_wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freq_cmd_q <= 16'h0000;
      step_idx_q <= 4'h0;
      jog_active_q <= 1'b0;
    end else begin
      step_idx_q <= spd_idx;
      jog_active_q <= term_q.jog;
      if (term_q.jog) begin
        freq_cmd_q <= jog_freq;
      end else if (spd_idx == 4'h0) begin
        freq_cmd_q <= base_freq;
      end else begin
        freq_cmd_q <= step_tbl_q[spd_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ramp_idx_q <= 3'h0;
    end else begin
      ramp_idx_q <= ramp_sel_en ? term_q.ramp : 3'h0;
    end
  end

  // Hysteresis detect: the band keeps the contact from chattering near the threshold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_hyst_q <= 1'b0;
    end else if (out_freq >= freq_detect) begin
      det_hyst_q <= 1'b1;
    end else if (17'(out_freq) < band_low(freq_detect, detect_band)) begin
      det_hyst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warn_cnt_q <= 16'h0000;
      overload_warning <= 1'b0;
    end else if (out_current < warn_level) begin
      warn_cnt_q <= 16'h0000;
      overload_warning <= 1'b0;
    end else begin
      if (tick_q && warn_cnt_q < 16'(warn_time) * 16'(WARN_UNIT_TICKS)) begin
        warn_cnt_q <= warn_cnt_q + 16'h0001;
      end
      overload_warning <= warn_cnt_q >= 16'(warn_time) * 16'(WARN_UNIT_TICKS);
    end
  end

  // Trip is sticky until fault_reset; a new trip in the reset cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      heavy_cnt_q <= 17'h00000;
      drive_overload <= 1'b0;
    end else begin
      if (out_current <= `HEAVY_LEVEL_PCT) begin
        heavy_cnt_q <= 17'h00000;
      end else if (tick_q && heavy_cnt_q < 17'(HEAVY_TRIP_TICKS)) begin
        heavy_cnt_q <= heavy_cnt_q + 17'h00001;
      end
      if (heavy_cnt_q >= 17'(HEAVY_TRIP_TICKS)) begin
        drive_overload <= 1'b1;
      end else if (fault_reset) begin
        drive_overload <= 1'b0;
      end
    end
  end

  // Relay pulse is stretched so that a mechanical contact can follow it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_q <= 8'h00;
    end else if (auto_seq_en && ((aux_sel == step_aux_pkg::AUX_STEP_PULSE && step_event) ||
                                 (aux_sel == step_aux_pkg::AUX_SEQ_PULSE && seq_event))) begin
      pulse_q <= 8'(PULSE_TICKS);
    end else if (tick_q && pulse_q != 8'h00) begin
      pulse_q <= pulse_q - 8'h01;
    end
  end

  // Reset starts in a gap so the contacts never close before an interlock has passed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= step_aux_pkg::LINE_GAP_DRIVE;
      gap_q <= 8'h00;
    end else begin
      unique case (line_q)
        step_aux_pkg::LINE_DRIVE: begin
          if (line_to_comm) begin
            line_q <= step_aux_pkg::LINE_GAP_COMM;
            gap_q <= 8'h00;
          end
        end
        step_aux_pkg::LINE_COMM: begin
          if (!line_to_comm) begin
            line_q <= step_aux_pkg::LINE_GAP_DRIVE;
            gap_q <= 8'h00;
          end
        end
        step_aux_pkg::LINE_GAP_COMM, step_aux_pkg::LINE_GAP_DRIVE: begin
          if (tick_q && gap_q == 8'(ILK_TICKS)) begin
            line_q <= line_to_comm ? step_aux_pkg::LINE_COMM : step_aux_pkg::LINE_DRIVE;
          end else if (tick_q) begin
            gap_q <= gap_q + 8'h01;
          end
        end
      endcase
    end
  end

  assign inv_line = line_q == step_aux_pkg::LINE_DRIVE;
  assign comm_line = line_q == step_aux_pkg::LINE_COMM;

  always_comb begin
    cond = 1'b0;
    unique case (aux_sel)
      step_aux_pkg::AUX_ARRIVE: cond = out_freq == ref_freq;
      step_aux_pkg::AUX_BAND_BOTH: begin
        cond = in_band(ref_freq, freq_detect, detect_band) &&
               in_band(out_freq, freq_detect, detect_band);
      end
      step_aux_pkg::AUX_BAND_OUT: cond = in_band(out_freq, freq_detect, detect_band);
      step_aux_pkg::AUX_HYST: cond = det_hyst_q;
      step_aux_pkg::AUX_HYST_INV: cond = !det_hyst_q;
      step_aux_pkg::AUX_WARN: cond = overload_warning;
      step_aux_pkg::AUX_HEAVY: cond = heavy_cnt_q >= 17'(HEAVY_WARN_TICKS);
      step_aux_pkg::AUX_STALL: cond = flags.stall;
      step_aux_pkg::AUX_DC_HIGH: cond = flags.dc_bus_high;
      step_aux_pkg::AUX_DC_LOW: cond = flags.dc_bus_low;
      step_aux_pkg::AUX_HOT: cond = flags.heatsink_hot;
      step_aux_pkg::AUX_LOST: cond = flags.ref_lost;
      step_aux_pkg::AUX_RUN: cond = flags.running;
      step_aux_pkg::AUX_STOP: cond = !flags.running;
      step_aux_pkg::AUX_STEADY: cond = flags.running && out_freq == ref_freq;
      step_aux_pkg::AUX_INV_LINE: cond = inv_line;
      step_aux_pkg::AUX_COMM_LINE: cond = comm_line;
      step_aux_pkg::AUX_SEARCH: cond = flags.speed_search;
      step_aux_pkg::AUX_STEP_PULSE, step_aux_pkg::AUX_SEQ_PULSE: cond = pulse_q != 8'h00;
      step_aux_pkg::AUX_READY: cond = misc.ready;
      step_aux_pkg::AUX_TRV_ACC: cond = misc.trv_acc;
      step_aux_pkg::AUX_TRV_DEC: cond = misc.trv_dec;
      step_aux_pkg::AUX_MMC: cond = misc.mmc;
      step_aux_pkg::AUX_ZSPD: cond = misc.zero_speed;
      step_aux_pkg::AUX_TORQ: cond = misc.torque_det;
      default: cond = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_relay_contact <= 1'b0;
    end else begin
      aux_relay_contact <= cond;
    end
  end

  always_comb begin
    meter_val = out_freq;
    meter_fs = meter_src.freq_max;
    unique case (meter_sel)
      step_aux_pkg::METER_FREQ: begin
        meter_val = out_freq;
        meter_fs = meter_src.freq_max;
      end
      step_aux_pkg::METER_CUR: begin
        meter_val = 16'(out_current);
        meter_fs = `PCT_FULL;
      end
      step_aux_pkg::METER_VOLT: begin
        meter_val = meter_src.volt;
        meter_fs = meter_src.volt_max;
      end
      step_aux_pkg::METER_DCBUS: begin
        meter_val = meter_src.dcbus;
        meter_fs = meter_src.dcbus_max;
      end
      step_aux_pkg::METER_TORQUE: begin
        meter_val = 16'(meter_src.torque_pct);
        meter_fs = `PCT_FULL;
      end
      default: begin
        meter_val = 16'h0000;
        meter_fs = `PCT_FULL;
      end
    endcase
  end

  meter_pwm u_meter (
    .clk(clk),
    .rstn(rstn),
    .value(meter_val),
    .full_scale(meter_fs),
    .gain(meter_gain),
    .cur_scale(meter_sel == step_aux_pkg::METER_CUR || meter_sel == step_aux_pkg::METER_TORQUE),
    .meter_pulse_out(meter_pulse_out)
  );

  // Counts interlock ticks seen with both line contacts open
  logic [7:0] open_ticks_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      open_ticks_q <= 8'h00;
    end else if (inv_line || comm_line) begin
      open_ticks_q <= 8'h00;
    end else if (tick_q && open_ticks_q != 8'hff) begin
      open_ticks_q <= open_ticks_q + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  jog_override_a: assert property (term_q.jog |=> freq_cmd_q == $past(jog_freq))
    else $error("jog frequency not applied");
  step_index_a: assert property (speed_sel_en |=> step_idx_q == $past(term_q.spd))
    else $error("step index differs from speed inputs");
  base_step_a: assert property ((!term_q.jog && spd_idx == 4'h0) |=>
    freq_cmd_q == $past(base_freq))
    else $error("index zero did not pick base frequency");
  ramp_select_a: assert property ((ramp_sel_en && term_q.ramp == 3'h5) |=>
    ramp_idx_q == 3'h5)
    else $error("ramp selection not followed");
  run_contact_a: assert property ((aux_sel == 5'h0c && flags.running) |=>
    aux_relay_contact)
    else $error("run contact not closed");
  hyst_inverse_a: assert property (aux_sel == 5'h04 |=>
    aux_relay_contact == !$past(det_hyst_q))
    else $error("inverted detect wrong");
  band_out_a: assert property ((aux_sel == 5'h02 && !in_band(out_freq, freq_detect,
    detect_band)) |=> !aux_relay_contact)
    else $error("contact closed outside band");
  line_exclusive_a: assert property (!(inv_line && comm_line))
    else $error("both line contacts closed");
  interlock_gap_a: assert property (($rose(inv_line) || $rose(comm_line)) |->
    open_ticks_q >= 8'(ILK_TICKS))
    else $error("line closed before interlock time");
  trip_time_a: assert property ($rose(drive_overload) |->
    $past(heavy_cnt_q) >= 17'(HEAVY_TRIP_TICKS))
    else $error("overload trip too early");
  warn_rise_a: assert property ($rose(overload_warning) |->
    $past(out_current >= warn_level))
    else $error("warning without overload current");

  jog_seen_c: cover property (term_q.jog ##1 !term_q.jog);
  comm_change_c: cover property ($rose(comm_line));
  trip_seen_c: cover property ($rose(drive_overload));
  step_pulse_c: cover property ($rose(pulse_q != 8'h00));
endmodule

// [verif/term_switches.sv]
// Terminal switch model that drives the raw multi-function input terminals
`timescale 1ns/10ps
module term_switches (
  input wire logic jog_sw,
  input wire logic [3:0] speed_sw,
  input wire logic [2:0] ramp_sw,
  output step_aux_pkg::term_in_t term_raw
);
  // Dry contacts wired straight in, closed reads high; no bounce, filter is set to zero except in t_filter
  assign term_raw = {jog_sw, speed_sw, ramp_sw};
endmodule

// [verif/step_aux_logic_tb.sv]
// Self-checking bench for the step speed and aux output logic
`timescale 1ns/10ps
module step_aux_logic_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic jog_sw = 1'b0;
  logic [3:0] speed_sw = 4'h0;
  logic [2:0] ramp_sw = 3'h0;
  step_aux_pkg::term_in_t term_raw;
  logic [7:0] filt_setting = 8'h00;
  logic speed_sel_en = 1'b1;
  logic ramp_sel_en = 1'b0;
  step_aux_pkg::freq_t base_freq = 16'h0555;
  step_aux_pkg::freq_t jog_freq = 16'h0777;
  logic step_wr_en = 1'b0;
  logic [3:0] step_wr_idx = 4'h0;
  step_aux_pkg::freq_t step_wr_data = 16'h0000;
  step_aux_pkg::freq_t out_freq = 16'h0000;
  step_aux_pkg::freq_t ref_freq = 16'h0000;
  step_aux_pkg::freq_t freq_detect = 16'h07d0;
  step_aux_pkg::freq_t detect_band = 16'h00c8;
  step_aux_pkg::pct_t out_current = 10'h000;
  step_aux_pkg::pct_t warn_level = 10'h064;
  logic [7:0] warn_time = 8'h0a;
  step_aux_pkg::drive_flags_t flags = '0;
  step_aux_pkg::aux_misc_t misc = '0;
  logic auto_seq_en = 1'b0;
  logic step_event = 1'b0;
  logic seq_event = 1'b0;
  logic line_to_comm = 1'b0;
  logic fault_reset = 1'b0;
  logic [4:0] aux_sel = 5'h1f;
  logic [2:0] meter_sel = 3'h0;
  logic [7:0] meter_gain = 8'h64;
  step_aux_pkg::meter_src_t meter_src = '0;
  step_aux_pkg::freq_t freq_cmd_q;
  logic [3:0] step_idx_q;
  logic jog_active_q;
  logic [2:0] ramp_idx_q;
  logic aux_relay_contact;
  logic overload_warning;
  logic drive_overload;
  logic inv_line;
  logic comm_line;
  logic meter_pulse_out;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [4:0] codes [7] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h11};

  always #20 clk = ~clk;

  term_switches term_switches_i (.jog_sw(jog_sw), .speed_sw(speed_sw), .ramp_sw(ramp_sw),
    .term_raw(term_raw));

  step_aux_logic #(.HALF_MS_CYCLES(4)) step_aux_logic_i (.clk(clk), .rstn(rstn),
    .term_raw(term_raw), .filt_setting(filt_setting), .speed_sel_en(speed_sel_en),
    .ramp_sel_en(ramp_sel_en), .base_freq(base_freq), .jog_freq(jog_freq),
    .step_wr_en(step_wr_en), .step_wr_idx(step_wr_idx), .step_wr_data(step_wr_data),
    .out_freq(out_freq), .ref_freq(ref_freq), .freq_detect(freq_detect),
    .detect_band(detect_band), .out_current(out_current), .warn_level(warn_level),
    .warn_time(warn_time), .flags(flags), .misc(misc), .auto_seq_en(auto_seq_en),
    .step_event(step_event), .seq_event(seq_event), .line_to_comm(line_to_comm),
    .fault_reset(fault_reset), .aux_sel(aux_sel), .meter_sel(meter_sel),
    .meter_gain(meter_gain), .meter_src(meter_src), .freq_cmd_q(freq_cmd_q),
    .step_idx_q(step_idx_q), .jog_active_q(jog_active_q), .ramp_idx_q(ramp_idx_q),
    .aux_relay_contact(aux_relay_contact), .overload_warning(overload_warning),
    .drive_overload(drive_overload), .inv_line(inv_line), .comm_line(comm_line),
    .meter_pulse_out(meter_pulse_out));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Three clocks covers the unfiltered terminal stage plus the output register
  task settle();
    repeat (3) @(negedge clk);
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task t_reset();
    repeat (8) @(negedge clk);
    check({15'h0000, aux_relay_contact}, 16'h0000);
    check(freq_cmd_q, 16'h0000);
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    speed_sw = 4'h5;
    settle();
    check(freq_cmd_q, 16'h0bb8);
    $display("test reset done");
  endtask

  task t_steps();
    for (int i = 1; i < 16; i++) begin
      step_wr_en = 1'b1;
      step_wr_idx = 4'(i);
      step_wr_data = 16'h0100 + 16'(i);
      @(negedge clk);
    end
    step_wr_en = 1'b0;
    for (int i = 0; i < 16; i++) begin
      speed_sw = 4'(i);
      settle();
      check({12'h000, step_idx_q}, 16'(i));
      check(freq_cmd_q, (i == 0) ? base_freq : 16'h0100 + 16'(i));
    end
    $display("test steps done");
  endtask

  task t_jog();
    speed_sw = 4'ha;
    jog_sw = 1'b1;
    settle();
    check(freq_cmd_q, jog_freq);
    check({15'h0000, jog_active_q}, 16'h0001);
    jog_sw = 1'b0;
    settle();
    check(freq_cmd_q, 16'h010a);
    $display("test jog done");
  endtask

  task t_ramp();
    ramp_sel_en = 1'b1;
    for (int r = 0; r < 8; r++) begin
      ramp_sw = 3'(r);
      settle();
      check({13'h0000, ramp_idx_q}, 16'(r));
    end
    ramp_sel_en = 1'b0;
    settle();
    check({13'h0000, ramp_idx_q}, 16'h0000);
    $display("test ramp done");
  endtask

  task t_aux_flags();
    for (int k = 0; k < 7; k++) begin
      aux_sel = codes[k];
      flags = 7'h40 >> k;
      settle();
      check({15'h0000, aux_relay_contact}, 16'h0001);
      flags = '0;
      settle();
      check({15'h0000, aux_relay_contact}, 16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      aux_sel = 5'(20 + k);
      misc = 6'h20 >> k;
      settle();
      check({15'h0000, aux_relay_contact}, 16'h0001);
    end
    misc = '0;
    aux_sel = 5'h0d;
    @(negedge clk);
    @(negedge clk);
    check({15'h0000, aux_relay_contact}, 16'h0001);
    aux_sel = 5'h1a;
    flags = '1;
    settle();
    check({15'h0000, aux_relay_contact}, 16'h0000);
    flags = '0;
    $display("test aux flags done");
  endtask

  task aux_at(input logic [4:0] code, input logic [15:0] outf, input logic exp);
    aux_sel = code;
    out_freq = outf;
    settle();
    check({15'h0000, aux_relay_contact}, {15'h0000, exp});
  endtask

  task t_freq();
    ref_freq = 16'h03e8;
    aux_at(5'h00, 16'h03e8, 1'b1);
    aux_at(5'h00, 16'h03e7, 1'b0);
    aux_at(5'h02, 16'h0802, 1'b1);
    aux_at(5'h02, 16'h0866, 1'b0);
    aux_at(5'h01, 16'h0802, 1'b0);
    ref_freq = 16'h07d0;
    aux_at(5'h01, 16'h0802, 1'b1);
    aux_at(5'h03, 16'h0000, 1'b0);
    aux_at(5'h03, 16'h07d0, 1'b1);
    aux_at(5'h03, 16'h079e, 1'b1);
    aux_at(5'h04, 16'h079e, 1'b0);
    aux_at(5'h03, 16'h0700, 1'b0);
    aux_at(5'h04, 16'h0700, 1'b1);
    $display("test freq detect done");
  endtask

  task t_line();
    int w;
    w = 0;
    while (inv_line !== 1'b1 && w < 600) begin
      @(negedge clk);
      w++;
    end
    check({15'h0000, inv_line}, 16'h0001);
    line_to_comm = 1'b1;
    @(negedge clk);
    @(negedge clk);
    check({14'h0000, inv_line, comm_line}, 16'h0000);
    // 50 ms at the scaled tick is 400 clocks; both must still be open near its end
    repeat (390) @(negedge clk);
    check({14'h0000, inv_line, comm_line}, 16'h0000);
    w = 0;
    while (comm_line !== 1'b1 && w < 60) begin
      @(negedge clk);
      w++;
    end
    check({14'h0000, inv_line, comm_line}, 16'h0001);
    line_to_comm = 1'b0;
    repeat (392) @(negedge clk);
    check({14'h0000, inv_line, comm_line}, 16'h0000);
    repeat (20) @(negedge clk);
    check({14'h0000, inv_line, comm_line}, 16'h0002);
    $display("test line exchange done");
  endtask

  // Four ticks of filter at four clocks a tick: the change lands 13 to 16 clocks later
  task t_filter();
    filt_setting = 8'h04;
    speed_sw = 4'h3;
    repeat (8) @(negedge clk);
    check({12'h000, step_idx_q}, 16'h000a);
    repeat (24) @(negedge clk);
    check({12'h000, step_idx_q}, 16'h0003);
    filt_setting = 8'h00;
    $display("test filter done");
  endtask

  // Warning time of 0.1 s is 200 ticks, about 800 clocks at the scaled tick
  task t_overload();
    aux_sel = 5'h05;
    warn_time = 8'h01;
    out_current = 10'h064;
    repeat (400) @(negedge clk);
    check({14'h0000, overload_warning, aux_relay_contact}, 16'h0000);
    repeat (500) @(negedge clk);
    check({14'h0000, overload_warning, aux_relay_contact}, 16'h0003);
    out_current = 10'h0c8;
    aux_sel = 5'h06;
    repeat (400) @(negedge clk);
    check({14'h0000, drive_overload, aux_relay_contact}, 16'h0000);
    out_current = 10'h000;
    settle();
    check({15'h0000, overload_warning}, 16'h0000);
    $display("test overload done");
  endtask

  task t_pulse();
    auto_seq_en = 1'b1;
    aux_sel = 5'h12;
    step_event = 1'b1;
    @(negedge clk);
    step_event = 1'b0;
    settle();
    check({15'h0000, aux_relay_contact}, 16'h0001);
    repeat (810) @(negedge clk);
    check({15'h0000, aux_relay_contact}, 16'h0000);
    auto_seq_en = 1'b0;
    $display("test step pulse done");
  endtask

  // Half of full scale for frequency, 75 of 100 percent current over divisor 150, at gain 100: 127 high clocks in each 256-clock period
  task t_meter();
    int hi;
    meter_src.freq_max = 16'h0100;
    out_freq = 16'h0080;
    out_current = 10'h04b;
    for (int m = 0; m < 2; m++) begin
      meter_sel = 3'(m);
      repeat (4) @(negedge clk);
      hi = 0;
      repeat (256) begin
        @(negedge clk);
        if (meter_pulse_out === 1'b1) begin
          hi++;
        end
      end
      check(16'(hi), 16'h007f);
    end
    $display("test meter done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    t_reset();
    t_steps();
    t_jog();
    t_ramp();
    t_aux_flags();
    t_freq();
    t_filter();
    t_overload();
    t_pulse();
    t_meter();
    t_line();
    report_and_stop();
  end
endmodule
